// ---- rtl/cmpc_pkg.sv ----
// package: constants and carrier types for codec mode and power control
package cmpc_pkg;

  localparam int unsigned MCLK_HZ        = 200_000_000;
  localparam int unsigned BCLK_PER_FRAME = 256;
  localparam int unsigned BCLK_HALF_CYC  = 4;
  localparam int unsigned FRAME_CYC      = BCLK_PER_FRAME * BCLK_HALF_CYC * 2;
  localparam int unsigned CNT_W          = $clog2(FRAME_CYC);
  localparam int unsigned BIAS_W         = 4;
  localparam int unsigned SLOT_W         = 4;
  localparam logic [4:0]  I2C_ADDR_HI    = 5'h1c;
  localparam logic [BIAS_W-1:0] BIAS_RST = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_RST  = '0;

  typedef enum logic [1:0]
  {
    CMPC_ST_RESET = 2'b00,
    CMPC_ST_RUN   = 2'b01,
    CMPC_ST_DOWN  = 2'b10
  } cmpc_state_t;

  typedef struct packed
  {
    logic power_down;
    logic master;
    logic two_wire;
  } cmpc_mode_t;

  typedef struct packed
  {
    logic             bclk;
    logic             frame_sync_line;
    logic             oe;
  } cmpc_link_t;

endpackage

// ---- rtl/cmpc_top.sv ----
// codec mode, reset and power-down control
`timescale 1ns/10ps
// Behaviour
// - control port select high: registers programmed over the two-wire bus
// - select low: register writes arrive in serial slots 0 and 1
// - two-wire selected: serial slots 0 and 1 are ignored
// - role select high makes the device frame master, low slave
// - power-down high gates drivers and fast clocks
// - serial and two-wire control paths stay alive in power-down
// - leaving power-down resumes with retained settings
// - power-down clears the counter, bit clock and frame sync output, never configuration
// - reset low loads every register with its default
// - all internal timing derives from the single master clock
// - a 4-bit control value sets the display bias output level
// - as master, bit clock runs at 256 times frame rate
// - two-wire address is 11100 followed by the two strap bits
// - frame starts at slot 0 when frame sync is high at bit clock rise
// - input latched on falling bit clock, output launched on rising
module cmpc_top
(
  // clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      rst_n_i,
  // mode pins
  input  wire logic                      power_down_pin_i,
  input  wire logic                      master_sel_i,
  input  wire logic                      two_wire_sel_i,
  input  wire logic                      addr_strap_high_i,
  input  wire logic                      addr_strap_low_i,
  // bias value written by whichever control port is active
  input  wire logic                      bias_wr_i,
  input  wire logic [3:0]                bias_data_i,
  // serial slot strobe, valid in slots 0 and 1
  input  wire logic                      slot_ctrl_i,
  input  wire logic [3:0]                slot_num_i,
  // frame link pins as seen by the block
  input  wire logic                      frame_sync_line_i,
  // outputs
  output logic                           bclk_o,
  output logic                           bclk_oe_o,
  output logic                           frame_sync_line_o,
  output logic                           frame_sync_line_oe_o,
  output logic                           drivers_en_o,
  output logic                           fast_clk_en_o,
  output logic                           ctrl_wr_o,
  output logic [3:0]                     display_bias_out_o,
  output logic [6:0]                     i2c_addr_o
);

  // two-stage synchronisers, first stage read only by the second
  cmpc_pkg::cmpc_mode_t meta_r, sync_r, meta_nxt, sync_nxt;

  always_comb
  begin
    meta_nxt.power_down = power_down_pin_i;
    meta_nxt.master     = master_sel_i;
    meta_nxt.two_wire   = two_wire_sel_i;
    sync_nxt            = meta_r;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  // state and counters
  cmpc_pkg::cmpc_state_t                 st_r, st_nxt;
  logic [cmpc_pkg::CNT_W-1:0]            cnt_r, cnt_nxt;
  logic [cmpc_pkg::BIAS_W-1:0]           bias_r, bias_nxt;
  logic [6:0]                            addr_r, addr_nxt;
  logic                                  bclk_r, bclk_nxt;
  logic                                  bclk_oe_r, bclk_oe_nxt;
  logic                                  fs_r, fs_nxt;
  logic                                  fs_oe_r, fs_oe_nxt;
  logic                                  drv_r, drv_nxt;
  logic                                  fclk_r, fclk_nxt;
  logic                                  wr_r, wr_nxt;
  logic                                  slot_ok;
  logic [cmpc_pkg::CNT_W-1:0]            fs_lead;

  // sync leads the frame by one full bit period
  assign fs_lead = cmpc_pkg::CNT_W'(cmpc_pkg::FRAME_CYC - 2 * cmpc_pkg::BCLK_HALF_CYC);

  // in-band writes only honoured in slots 0 and 1 with serial control chosen
  assign slot_ok = slot_ctrl_i && !sync_r.two_wire && (slot_num_i < 4'h2);

  always_comb
  begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    bias_nxt    = bias_r;
    addr_nxt    = addr_r;
    bclk_nxt    = bclk_r;
    fs_nxt      = 1'b0;
    wr_nxt      = 1'b0;
    bclk_oe_nxt = sync_r.master;
    fs_oe_nxt   = sync_r.master;
    drv_nxt     = !sync_r.power_down;
    fclk_nxt    = !sync_r.power_down;
    unique case (st_r)
      cmpc_pkg::CMPC_ST_RESET:
      begin
        // strap capture after release, never under reset
        addr_nxt = {cmpc_pkg::I2C_ADDR_HI, addr_strap_high_i, addr_strap_low_i};
        st_nxt   = cmpc_pkg::CMPC_ST_RUN;
      end
      cmpc_pkg::CMPC_ST_RUN:
      begin
        if (sync_r.power_down)
        begin
          st_nxt   = cmpc_pkg::CMPC_ST_DOWN;
          cnt_nxt  = cmpc_pkg::CNT_RST;
          bclk_nxt = 1'b0;
        end
        else
        begin
          // divider from master clock: 256 bit clocks per frame
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == cmpc_pkg::CNT_W'(cmpc_pkg::FRAME_CYC - 1))
            cnt_nxt = cmpc_pkg::CNT_RST;
          // equal halves put the falling edge mid-bit for input latching
          if (cnt_r[$clog2(cmpc_pkg::BCLK_HALF_CYC)-1:0] == '0)
            bclk_nxt = !bclk_r;
          // sync spans the last bit period, so it is stable high at the first rise
          fs_nxt = sync_r.master && (cnt_r >= fs_lead);
          // slave: restart the count on the host's sync so slots line up
          if (!sync_r.master && frame_sync_line_i)
          begin
            cnt_nxt  = cmpc_pkg::CNT_RST;
            bclk_nxt = 1'b0;
          end
        end
      end
      cmpc_pkg::CMPC_ST_DOWN:
      begin
        cnt_nxt = cmpc_pkg::CNT_RST;
        if (!sync_r.power_down)
          st_nxt = cmpc_pkg::CMPC_ST_RUN;
      end
      default:
        st_nxt = cmpc_pkg::CMPC_ST_RESET;
    endcase
    // control writes stay live in power-down; config is never cleared there
    if ((bias_wr_i && sync_r.two_wire && !slot_ctrl_i) || (bias_wr_i && slot_ok))
    begin
      bias_nxt = bias_data_i;
      wr_nxt   = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r      <= cmpc_pkg::CMPC_ST_RESET;
      cnt_r     <= cmpc_pkg::CNT_RST;
      bias_r    <= cmpc_pkg::BIAS_RST;
      addr_r    <= '0;
      bclk_r    <= 1'b0;
      bclk_oe_r <= 1'b0;
      fs_r      <= 1'b0;
      fs_oe_r   <= 1'b0;
      drv_r     <= 1'b0;
      fclk_r    <= 1'b0;
      wr_r      <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      bias_r    <= bias_nxt;
      addr_r    <= addr_nxt;
      bclk_r    <= bclk_nxt;
      bclk_oe_r <= bclk_oe_nxt;
      fs_r      <= fs_nxt;
      fs_oe_r   <= fs_oe_nxt;
      drv_r     <= drv_nxt;
      fclk_r    <= fclk_nxt;
      wr_r      <= wr_nxt;
    end
  end

  assign bclk_o               = bclk_r;
  assign bclk_oe_o            = bclk_oe_r;
  assign frame_sync_line_o    = fs_r;
  assign frame_sync_line_oe_o = fs_oe_r;
  assign drivers_en_o         = drv_r;
  assign fast_clk_en_o        = fclk_r;
  assign ctrl_wr_o            = wr_r;
  assign display_bias_out_o   = bias_r;
  assign i2c_addr_o           = addr_r;

  // assertions
  property p_two_wire_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (bias_wr_i && sync_r.two_wire && !slot_ctrl_i) |=> (display_bias_out_o == $past(bias_data_i));
  endproperty
  a_two_wire_write: assert property (p_two_wire_write) else $error("two-wire write not applied");

  property p_slot_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (bias_wr_i && !sync_r.two_wire && slot_ctrl_i && slot_num_i < 4'h2) |=> ctrl_wr_o;
  endproperty
  a_slot_write: assert property (p_slot_write) else $error("slot write lost");

  property p_slot_ignored;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!bias_wr_i || (sync_r.two_wire && slot_ctrl_i) || (!sync_r.two_wire && !slot_ctrl_i)) |=> !ctrl_wr_o;
  endproperty
  a_slot_ignored: assert property (p_slot_ignored) else $error("write taken from ignored source");

  property p_role;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sync_r.master |=> (bclk_oe_o && frame_sync_line_oe_o);
  endproperty
  a_role: assert property (p_role) else $error("master role not driving link");

  property p_frame_start;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == cmpc_pkg::CMPC_ST_RUN && !sync_r.power_down && sync_r.master &&
       cnt_r == cmpc_pkg::CNT_W'(cmpc_pkg::FRAME_CYC - 1)) |=> (frame_sync_line_o && !bclk_o);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("sync not high before frame bit clock rise");

  property p_slave_align;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == cmpc_pkg::CMPC_ST_RUN && !sync_r.power_down && !sync_r.master && frame_sync_line_i)
        |=> (cnt_r == '0);
  endproperty
  a_slave_align: assert property (p_slave_align) else $error("slave frame not realigned");

  property p_down_gates;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sync_r.power_down |=> (!drivers_en_o && !fast_clk_en_o);
  endproperty
  a_down_gates: assert property (p_down_gates) else $error("drivers live in power-down");

  property p_bias_kept;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == cmpc_pkg::CMPC_ST_DOWN && !bias_wr_i) |=> $stable(display_bias_out_o);
  endproperty
  a_bias_kept: assert property (p_bias_kept) else $error("config lost in power-down");

  property p_cnt_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == cmpc_pkg::CMPC_ST_DOWN) |=> (cnt_r == '0);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");

  property p_resume;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == cmpc_pkg::CMPC_ST_DOWN && !sync_r.power_down) |=> (st_r == cmpc_pkg::CMPC_ST_RUN);
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after power-down");

  property p_addr;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == cmpc_pkg::CMPC_ST_RUN) |-> (i2c_addr_o[6:2] == 5'h1c);
  endproperty
  a_addr: assert property (p_addr) else $error("bus address upper bits wrong");

  property p_sync_pipe;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(power_down_pin_i) ##1 power_down_pin_i |-> !sync_r.power_down ##1 sync_r.power_down;
  endproperty
  a_sync_pipe: assert property (p_sync_pipe) else $error("synchroniser depth wrong");

endmodule

// ---- bench/cmpc_host.sv ----
// host model: frame sync source and bias writes over either control port
`timescale 1ns/10ps
module cmpc_host
#(
  parameter int FRAME_PER = 12500
)
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // control writes and frame sync toward the block
  output logic            bias_wr_o,
  output logic [3:0]      bias_data_o,
  output logic            slot_ctrl_o,
  output logic [3:0]      slot_num_o,
  output logic            frame_sync_o
);
  int unsigned cnt;

  initial
  begin
    bias_wr_o   = 1'b0;
    bias_data_o = 4'h0;
    slot_ctrl_o = 1'b0;
    slot_num_o  = 4'h0;
  end

  // 16 kHz frames at 200 MHz, sync high in the first cycle
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt          <= 0;
      frame_sync_o <= 1'b0;
    end
    else
    begin
      cnt          <= (cnt == FRAME_PER - 1) ? 0 : cnt + 1;
      frame_sync_o <= (cnt == 0);
    end
  end

  // released data and slot number lines show the inverse so stale data cannot pass unseen
  task automatic write(input logic slot, input logic [3:0] num, input logic [3:0] data);
    @(posedge mclk_i);
    bias_wr_o   <= 1'b1;
    bias_data_o <= data;
    slot_ctrl_o <= slot;
    slot_num_o  <= num;
    @(posedge mclk_i);
    bias_wr_o   <= 1'b0;
    bias_data_o <= ~data;
    slot_ctrl_o <= 1'b0;
    slot_num_o  <= ~num;
  endtask
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for codec mode and power control
`timescale 1ns/10ps
module testbench;
  logic mclk_i, rst_n_i, pd, ms, tw, ah, al, wr, sc, fsi;
  logic [3:0] bd, sn;
  logic bclk_o, bclk_oe_o, fs_o, fs_oe_o, drv_o, fck_o, cwr_o;
  logic [3:0] bias_o;
  logic [6:0] addr_o;
  int error_cnt, total_checks, cyc;

  cmpc_host u_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bias_wr_o(wr), .bias_data_o(bd),
    .slot_ctrl_o(sc), .slot_num_o(sn), .frame_sync_o(fsi));
  cmpc_top u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .power_down_pin_i(pd), .master_sel_i(ms),
    .two_wire_sel_i(tw), .addr_strap_high_i(ah), .addr_strap_low_i(al), .bias_wr_i(wr),
    .bias_data_i(bd), .slot_ctrl_i(sc), .slot_num_i(sn), .frame_sync_line_i(fsi), .bclk_o(bclk_o),
    .bclk_oe_o(bclk_oe_o), .frame_sync_line_o(fs_o), .frame_sync_line_oe_o(fs_oe_o),
    .drivers_en_o(drv_o), .fast_clk_en_o(fck_o), .ctrl_wr_o(cwr_o), .display_bias_out_o(bias_o),
    .i2c_addr_o(addr_o));

  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic end_of_test;
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  // a refused write must leave the bias and the strobe untouched
  task automatic wrt(input logic s, input logic [3:0] n, input logic [3:0] d, input logic [3:0] eb,
                     input logic acc);
    u_host.write(s, n, d);
    #1;
    chk("ctrl_wr", acc, cwr_o);
    chk("bias", eb, bias_o);
  endtask

  // three edges of pin sync before outputs follow; one spare
  task automatic pins(input logic p, input logic m, input logic t);
    @(posedge mclk_i);
    pd <= p;
    ms <= m;
    tw <= t;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask

  task automatic t_two_wire;
    repeat (4) @(posedge mclk_i);
    #1;
    chk("addr", {cmpc_pkg::I2C_ADDR_HI, 2'b10}, addr_o);
    chk("bias_rst", cmpc_pkg::BIAS_RST, bias_o);
    chk("drv_en", 1'b1, drv_o);
    wrt(1'b0, 4'h0, 4'h5, 4'h5, 1'b1);
    wrt(1'b0, 4'h0, 4'hf, 4'hf, 1'b1);
    wrt(1'b1, 4'h0, 4'h3, 4'hf, 1'b0);
    wrt(1'b1, 4'h1, 4'h3, 4'hf, 1'b0);
  endtask

  task automatic t_serial;
    pins(1'b0, 1'b0, 1'b0);
    wrt(1'b1, 4'h0, 4'ha, 4'ha, 1'b1);
    wrt(1'b1, 4'h1, 4'h6, 4'h6, 1'b1);
    wrt(1'b1, 4'h2, 4'h9, 4'h6, 1'b0);
    wrt(1'b0, 4'h0, 4'h9, 4'h6, 1'b0);
  endtask

  // bit clock rises between two frame sync rises
  task automatic t_master;
    int n, f, nf;
    logic pb, pf;
    pins(1'b0, 1'b1, 1'b0);
    n = 0;
    nf = 0;
    f = 0;
    pb = bclk_o;
    pf = fs_o;
    repeat (4200)
    begin
      @(posedge mclk_i);
      #1;
      if (f == 1 && bclk_o && !pb) n++;
      if (f == 1 && !bclk_o && pb) nf++;
      if (fs_o && !pf) f++;
      pb = bclk_o;
      pf = fs_o;
    end
    chk("bclk_oe", 1'b1, bclk_oe_o);
    chk("fs_oe", 1'b1, fs_oe_o);
    chk("bclk_per_frame", 16'd256, 16'(n));
    chk("bclk_falls", 16'h100, 16'(nf));
  endtask

  task automatic t_power;
    pins(1'b1, 1'b1, 1'b0);
    chk("drv_en", 1'b0, drv_o);
    chk("fast_en", 1'b0, fck_o);
    chk("bclk_stop", 1'b0, bclk_o);
    wrt(1'b1, 4'h0, 4'h7, 4'h7, 1'b1);
    pins(1'b0, 1'b1, 1'b0);
    chk("drv_en", 1'b1, drv_o);
    chk("fast_en", 1'b1, fck_o);
    chk("bias_kept", 4'h7, bias_o);
    pins(1'b0, 1'b0, 1'b0);
    chk("bclk_oe", 1'b0, bclk_oe_o);
    chk("fs_oe", 1'b0, fs_oe_o);
  endtask

  task automatic t_reset_mid;
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    ah <= 1'b0;
    al <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    chk("bias_rst", 4'h0, bias_o);
    chk("drv_rst", 1'b0, drv_o);
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    chk("addr", {cmpc_pkg::I2C_ADDR_HI, 2'b01}, addr_o);
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    pd = 1'b0;
    ms = 1'b0;
    tw = 1'b1;
    ah = 1'b1;
    al = 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
    chk("drv_rst", 1'b0, drv_o);
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_two_wire();
    t_serial();
    t_master();
    t_power();
    t_reset_mid();
    end_of_test();
  end
endmodule
